// file: rtl/bti_delay_timer.sv
`timescale 1ns/1ps
`default_nettype none
module bti_delay_timer
    import bti_pkg::*;
(
    // clock and reset
    input  wire logic        mclk_i,
    input  wire logic        nrst_i,
    // control
    input  wire logic        start_i,
    input  wire logic [15:0] len_i,
    output logic             busy_o
);

    // ========================================================================
    // cycle countdown
    // ========================================================================
    logic [15:0] rem;
    logic [15:0] next_rem;

    always_comb begin
        next_rem = rem;
        if (start_i) begin
            next_rem = len_i;
        end else if (rem != 16'h0000) begin
            next_rem = rem - 16'h0001;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            rem <= 16'h0000;
        end else begin
            rem <= next_rem;
        end
    end

    assign busy_o = (rem != 16'h0000);

endmodule : bti_delay_timer
`default_nettype wire

// file: rtl/bti_field_asm.sv
`timescale 1ns/1ps
`default_nettype none
module bti_field_asm
    import bti_pkg::*;
(
    // clock and reset
    input  wire logic        mclk_i,
    input  wire logic        nrst_i,
    // byte in
    input  wire logic        byte_vld_i,
    input  wire logic [7:0]  byte_i,
    input  wire logic        clear_i,
    // assembled word out
    output logic             word_vld_o,
    output logic [31:0]      word_o
);

    // ========================================================================
    // msb-first shift of four bytes
    // ========================================================================
    logic [31:0] shreg;
    logic [1:0]  cnt;
    logic        vld;
    logic [31:0] next_shreg;
    logic [1:0]  next_cnt;
    logic        next_vld;

    always_comb begin
        next_shreg = shreg;
        next_cnt   = cnt;
        next_vld   = 1'b0;
        if (clear_i) begin
            next_cnt = 2'h0;
        end else if (byte_vld_i) begin
            next_shreg = {shreg[23:0], byte_i};
            next_cnt   = cnt + 2'h1;
            next_vld   = (cnt == LAST_BYTE_IDX);
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            shreg <= 32'h0000_0000;
            cnt   <= 2'h0;
            vld   <= 1'b0;
        end else begin
            shreg <= next_shreg;
            cnt   <= next_cnt;
            vld   <= next_vld;
        end
    end

    assign word_o     = shreg;
    assign word_vld_o = vld;

endmodule : bti_field_asm
`default_nettype wire

// file: rtl/bti_loader.sv
// Overview of operation
// RULE1: first field is the saved entry address
// RULE2: second field counts configuration entries
// RULE3: zero count skips straight to sections
// RULE4: entry is port address then value
// RULE5: writes go to ports before sections
// RULE6: port half ffff means delay request
// RULE7: delay stalls parsing for given cycles
// RULE8: only ports below ffef are written
// RULE9: entries run strictly in table order
// RULE10: after last entry read sections
// RULE11: section copies exactly its byte count
// RULE12: data goes from destination address upward
// RULE13: zero section count ends and branches
// RULE14: same parsing for every boot source
// RULE15: values written with no checks
// RULE16: entry address kept at words 60h/61h
// RULE17: stack regions at 90h and 80h reserved
// RULE18: producer keeps sections above word 100h
// RULE19: producer leaves serial port registers alone
// RULE20: producer keeps table space memory type
// RULE21: counts and addresses fit 24 bits
// RULE22: msb-first fields, done on branch
`timescale 1ns/1ps
`default_nettype none
module bti_loader
    import bti_pkg::*;
(
    // clock and reset
    input  wire logic        mclk_i,
    input  wire logic        nrst_i,
    // byte stream from any boot source
    input  wire logic        byte_vld_i,
    input  wire logic [7:0]  byte_i,
    output logic             byte_rdy_o,
    // peripheral port writes
    output logic             port_wr_o,
    output bti_port_wr_t     port_o,
    // memory byte writes
    output logic             mem_wr_o,
    output bti_mem_wr_t      mem_o,
    // loader scratch word writes
    output logic             word_wr_o,
    output bti_word_wr_t     word_o,
    // completion
    output logic             done_o,
    output logic [23:0]      entry_o
);

    // ========================================================================
    // state
    // ========================================================================
    typedef enum logic [2:0] {
        ST_ENTRY,
        ST_SAVE_HI,
        ST_CFG_CNT,
        ST_CFG_ENT,
        ST_DELAY,
        ST_SEC_CNT,
        ST_SEC_ADDR,
        ST_DATA
    } bti_state_t;

    bti_state_t   st, next_st;
    logic [31:0]  cfg_left, next_cfg_left;
    logic [23:0]  sec_left, next_sec_left;
    logic [23:0]  dst, next_dst;
    logic [23:0]  entry, next_entry;
    logic         done, next_done;
    logic         rdy, next_rdy;
    logic         pwr, next_pwr;
    bti_port_wr_t port, next_port;
    logic         mwr, next_mwr;
    bti_mem_wr_t  mem, next_mem;
    logic         wwr, next_wwr;
    bti_word_wr_t word, next_word;
    logic         dly_start;
    logic         dly_busy;
    logic         asm_clear;
    logic         fw_vld;
    logic [31:0]  fw;
    logic         take;

    // the source only sees ready; bytes offered while not ready are not taken
    assign take = byte_vld_i && rdy;

    // ========================================================================
    // helpers
    // ========================================================================
    function automatic logic [23:0] lo24(input logic [31:0] w);
        lo24 = w[23:0] & ADDR_MASK; // see RULE21
    endfunction : lo24

    function automatic logic is_write_port(input logic [15:0] a);
        is_write_port = (a < WRITE_LIMIT); // see RULE8
    endfunction : is_write_port

    // ========================================================================
    // submodules: one field assembler serves all sources alike
    // ========================================================================
    bti_field_asm u_asm (
        .mclk_i     (mclk_i),
        .nrst_i     (nrst_i),
        .byte_vld_i (take && (st != ST_DATA)),
        .byte_i     (byte_i),
        .clear_i    (asm_clear),
        .word_vld_o (fw_vld),
        .word_o     (fw)
    ); // see RULE14 see RULE22

    bti_delay_timer u_dly (
        .mclk_i  (mclk_i),
        .nrst_i  (nrst_i),
        .start_i (dly_start),
        .len_i   (fw[15:0]),
        .busy_o  (dly_busy)
    );

    // ========================================================================
    // parser
    // ========================================================================
    always_comb begin
        next_st       = st;
        next_cfg_left = cfg_left;
        next_sec_left = sec_left;
        next_dst      = dst;
        next_entry    = entry;
        next_done     = done;
        next_rdy      = rdy;
        next_pwr      = 1'b0;
        next_port     = port;
        next_mwr      = 1'b0;
        next_mem      = mem;
        next_wwr      = 1'b0;
        next_word     = word;
        dly_start     = 1'b0;
        asm_clear     = 1'b0;
        unique case (st)
            ST_ENTRY: begin
                if (fw_vld) begin
                    next_entry = lo24(fw); // see RULE1
                    next_wwr   = 1'b1;
                    next_word  = '{waddr: ENTRY_LO_WADDR, data: fw[15:0]}; // see RULE16
                    next_st    = ST_SAVE_HI;
                end
            end
            ST_SAVE_HI: begin
                next_wwr  = 1'b1;
                next_word = '{waddr: ENTRY_HI_WADDR, data: 16'(entry >> 16)}; // see RULE16
                next_st   = ST_CFG_CNT;
            end
            ST_CFG_CNT: begin
                if (fw_vld) begin
                    next_cfg_left = fw; // see RULE2
                    next_st = (fw == END_COUNT) ? ST_SEC_CNT : ST_CFG_ENT; // see RULE3
                end
            end
            ST_CFG_ENT: begin
                if (fw_vld) begin
                    next_cfg_left = cfg_left - 32'h0000_0001; // see RULE9
                    if (fw[31:16] == DELAY_MARK) begin // see RULE6
                        dly_start = 1'b1;
                        next_rdy  = 1'b0;
                        next_st   = ST_DELAY;
                    end else begin
                        // reserved ports ff ef..ff fe are silently skipped
                        next_pwr  = is_write_port(fw[31:16]); // see RULE5 see RULE8
                        next_port = '{addr: fw[31:16], data: fw[15:0]}; // see RULE4 see RULE15
                        if (cfg_left == 32'h0000_0001) begin
                            next_st = ST_SEC_CNT; // see RULE10
                        end
                    end
                end
            end
            ST_DELAY: begin
                if (!dly_busy) begin // see RULE7
                    next_rdy = 1'b1;
                    next_st  = (cfg_left == END_COUNT) ? ST_SEC_CNT : ST_CFG_ENT;
                end
            end
            ST_SEC_CNT: begin
                if (fw_vld) begin
                    next_sec_left = lo24(fw); // see RULE11
                    if (fw == END_COUNT) begin // see RULE13
                        next_done = 1'b1;
                        next_rdy  = 1'b0;
                    end else begin
                        next_st = ST_SEC_ADDR;
                    end
                end
            end
            ST_SEC_ADDR: begin
                if (fw_vld) begin
                    next_dst = lo24(fw); // see RULE12
                    next_st  = ST_DATA;
                end
            end
            ST_DATA: begin
                if (take) begin
                    next_mwr      = 1'b1;
                    next_mem      = '{addr: dst, data: byte_i}; // see RULE12
                    next_dst      = dst + 24'h00_0001;
                    next_sec_left = sec_left - 24'h00_0001; // see RULE11
                    if (sec_left == 24'h00_0001) begin
                        asm_clear = 1'b1;
                        next_st   = ST_SEC_CNT;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            st       <= ST_ENTRY;
            cfg_left <= 32'h0000_0000;
            sec_left <= 24'h00_0000;
            dst      <= 24'h00_0000;
            entry    <= 24'h00_0000;
            done     <= 1'b0;
            rdy      <= 1'b1;
            pwr      <= 1'b0;
            port     <= '0;
            mwr      <= 1'b0;
            mem      <= '0;
            wwr      <= 1'b0;
            word     <= '0;
        end else begin
            st       <= next_st;
            cfg_left <= next_cfg_left;
            sec_left <= next_sec_left;
            dst      <= next_dst;
            entry    <= next_entry;
            done     <= next_done;
            rdy      <= next_rdy;
            pwr      <= next_pwr;
            port     <= next_port;
            mwr      <= next_mwr;
            mem      <= next_mem;
            wwr      <= next_wwr;
            word     <= next_word;
        end
    end

    assign byte_rdy_o = rdy;
    assign port_wr_o  = pwr;
    assign port_o     = port;
    assign mem_wr_o   = mwr;
    assign mem_o      = mem;
    assign word_wr_o  = wwr;
    assign word_o     = word;
    assign done_o     = done;
    assign entry_o    = entry;

    // ========================================================================
    // checks
    // ========================================================================
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);

    port_range_a: assert property (port_wr_o |-> port_o.addr < WRITE_LIMIT) // see RULE8
        else $error("port write to reserved address");
    no_mark_write_a: assert property (port_wr_o |-> port_o.addr != DELAY_MARK) // see RULE6
        else $error("delay mark written as port");
    delay_stall_a: assert property ((st == ST_DELAY) && dly_busy |-> !byte_rdy_o) // see RULE7
        else $error("stream taken during delay");
    cfg_before_sec_a: assert property (port_wr_o |-> !$past(mem_wr_o) && !done_o) // see RULE5
        else $error("port write after section phase");
    done_sticky_a: assert property (done_o |=> done_o && !byte_rdy_o && !mem_wr_o) // see RULE13
        else $error("activity after end of table");
    mem_incr_a: assert property ( // see RULE12
        mem_wr_o && $past(mem_wr_o) && $past(st) == ST_DATA && st == ST_DATA
        |-> mem_o.addr == $past(mem_o.addr) + 24'h00_0001)
        else $error("section address not sequential");
    entry_save_a: assert property ($rose(st == ST_SAVE_HI) |-> word_wr_o // see RULE16
        && word_o.waddr == ENTRY_LO_WADDR ##1 word_wr_o && word_o.waddr == ENTRY_HI_WADDR)
        else $error("entry address not saved");
    entry_hold_a: assert property (st != ST_ENTRY && !$past(st == ST_ENTRY) // see RULE1
        |-> $stable(entry_o))
        else $error("entry address changed");
    zero_cfg_a: assert property (st == ST_CFG_CNT && fw_vld && fw == END_COUNT // see RULE3
        |=> st == ST_SEC_CNT)
        else $error("zero count did not skip");
    // the loader stacks share the scratch area, so the entry save must miss them
    stack_clear_a: assert property (word_wr_o // see RULE17
        |-> word_o.waddr != STACK_WADDR && word_o.waddr != SYS_STACK_WADDR)
        else $error("scratch write into stack region");
    // ready must fall on the very edge the delay starts, or a byte slips in
    delay_stop_a: assert property ( // see RULE7
        st == ST_CFG_ENT && fw_vld && fw[31:16] == DELAY_MARK
        |=> st == ST_DELAY && !byte_rdy_o)
        else $error("delay entry did not stall");
    end_from_count_a: assert property ($rose(done_o) |-> $past(st) == ST_SEC_CNT) // see RULE13
        else $error("end seen outside a section count");

    cfg_write_c: cover property (port_wr_o);
    skip_cfg_c: cover property (st == ST_CFG_CNT && fw_vld && fw == END_COUNT);
    delay_done_c: cover property ((st == ST_DELAY) ##1 (st == ST_DELAY)[*3] ##1 byte_rdy_o);
    data_copy_c: cover property (mem_wr_o ##1 mem_wr_o);
    finish_c: cover property ($rose(done_o));

endmodule : bti_loader
`default_nettype wire

// file: rtl/bti_pkg.sv
package bti_pkg;

    // ========================================================================
    // table field layout
    // ========================================================================
    localparam int          FIELD_BYTES    = 4;
    localparam logic [1:0]  LAST_BYTE_IDX  = 2'h3;
    localparam logic [15:0] DELAY_MARK     = 16'hffff;
    localparam logic [15:0] WRITE_LIMIT    = 16'hffef;
    localparam logic [31:0] END_COUNT      = 32'h0000_0000;
    localparam int          ADDR_W         = 24;
    localparam logic [23:0] ADDR_MASK      = 24'hff_ffff;

    // ========================================================================
    // reserved loader memory, word addresses and one byte address (SAFE_BADDR)
    // ========================================================================
    localparam logic [23:0] ENTRY_LO_WADDR = 24'h00_0060;
    localparam logic [23:0] ENTRY_HI_WADDR = 24'h00_0061;
    localparam logic [23:0] STACK_WADDR    = 24'h00_0090;
    localparam logic [23:0] SYS_STACK_WADDR = 24'h00_0080;
    localparam logic [23:0] SAFE_WADDR     = 24'h00_0100;
    localparam logic [23:0] SAFE_BADDR     = 24'h00_0200;

    // ========================================================================
    // shared types
    // ========================================================================
    typedef enum logic [2:0] {
        BTI_F_ENTRY,
        BTI_F_CFG_CNT,
        BTI_F_CFG_ENT,
        BTI_F_SEC_CNT,
        BTI_F_SEC_ADDR,
        BTI_F_DATA
    } bti_field_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] data;
    } bti_port_wr_t;

    typedef struct packed {
        logic [23:0] addr;
        logic [7:0]  data;
    } bti_mem_wr_t;

    typedef struct packed {
        logic [23:0] waddr;
        logic [15:0] data;
    } bti_word_wr_t;

endpackage : bti_pkg

// file: verif/boot_table_interpreter_tb.sv
`timescale 1ns/1ps
`default_nettype none
module boot_table_interpreter_tb
    import bti_pkg::*;
;
    // ========================================================================
    // signals
    // ========================================================================
    logic         mclk_i;
    logic         nrst_i;
    logic         byte_vld;
    logic [7:0]   byte_v;
    logic         byte_rdy_o;
    logic         port_wr_o;
    bti_port_wr_t port_o;
    logic         mem_wr_o;
    bti_mem_wr_t  mem_o;
    logic         word_wr_o;
    bti_word_wr_t word_o;
    logic         done_o;
    logic [23:0]  entry_o;
    int           err_total;
    int           n_tests;
    int           cyc;
    int           last_port;
    int           first_mem;
    int           low_run;
    int           low_q[$];
    bti_port_wr_t pw_q[$];
    bti_mem_wr_t  mw_q[$];
    bti_word_wr_t ww_q[$];

    bti_loader dut_u (
        .mclk_i(mclk_i), .nrst_i(nrst_i), .byte_vld_i(byte_vld), .byte_i(byte_v),
        .byte_rdy_o(byte_rdy_o), .port_wr_o(port_wr_o), .port_o(port_o),
        .mem_wr_o(mem_wr_o), .mem_o(mem_o), .word_wr_o(word_wr_o), .word_o(word_o),
        .done_o(done_o), .entry_o(entry_o)
    );

    bti_boot_media media_u (
        .mclk_i(mclk_i), .byte_rdy_i(byte_rdy_o), .byte_vld_o(byte_vld), .byte_o(byte_v)
    );

    initial begin
        mclk_i = 1'b0;
        forever #12.5 mclk_i = ~mclk_i;
    end

    // ========================================================================
    // monitor, sampled mid-cycle where registered outputs are settled
    // ========================================================================
    always @(negedge mclk_i) begin
        cyc = cyc + 1;
        if (port_wr_o === 1'b1) begin
            pw_q.push_back(port_o);
            last_port = cyc;
        end
        if (mem_wr_o === 1'b1) begin
            mw_q.push_back(mem_o);
            if (first_mem < 0) first_mem = cyc;
        end
        if (word_wr_o === 1'b1) ww_q.push_back(word_o);
        if (byte_rdy_o === 1'b0 && done_o === 1'b0) low_run = low_run + 1;
        else if (low_run != 0) begin
            low_q.push_back(low_run);
            low_run = 0;
        end
    end

    // ========================================================================
    // helpers
    // ========================================================================
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : finish_test

    task automatic do_reset(input int n);
        @(negedge mclk_i);
        nrst_i = 1'b0;
        media_u.flush();
        repeat (n) @(negedge mclk_i);
        chk("rdy in reset", 1, byte_rdy_o);
        chk("done in reset", 0, done_o);
        chk("entry in reset", 0, entry_o);
        pw_q.delete();
        mw_q.delete();
        ww_q.delete();
        low_q.delete();
        low_run   = 0;
        first_mem = -1;
        last_port = 0;
        nrst_i    = 1'b1;
    endtask : do_reset

    // fields go msb first; the last byte leaves two more spare cycles than the rest
    task automatic put_field(input logic [31:0] v, input int g);
        for (int i = 0; i < 3; i++) media_u.push(v[31-8*i -: 8], g);
        media_u.push(v[7:0], g + 2);
    endtask : put_field

    task automatic wait_done();
        int k;
        k = 0;
        while (done_o !== 1'b1 && k < 3000) begin
            @(negedge mclk_i);
            k++;
        end
        chk("done", 1, done_o);
        repeat (10) @(negedge mclk_i);
    endtask : wait_done

    // ========================================================================
    // scenarios
    // ========================================================================
    task automatic scen_full();
        logic [7:0]  dat[6] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'haa, 8'h55};
        logic [23:0] adr[6] = '{24'h200, 24'h201, 24'h202, 24'h203, 24'ha0001, 24'ha0002};
        do_reset(20);
        put_field(32'h0012_3456, 0);
        put_field(32'h0000_0005, 0);
        put_field(32'h1c00_2180, 0);
        put_field(32'hffef_5555, 0);
        put_field(32'hffff_0001, 0);
        put_field(32'hffee_1234, 0);
        put_field(32'hffff_0028, 0);
        put_field(32'h0000_0004, 0);
        put_field(32'h0000_0200, 0);
        for (int i = 0; i < 4; i++) media_u.push(dat[i], 0);
        put_field(32'h0000_0002, 0);
        put_field(32'h000a_0001, 0);
        media_u.push(dat[4], 3);
        media_u.push(dat[5], 2);
        put_field(32'h0000_0000, 0);
        media_u.push(8'h77, 0);
        wait_done();
        chk("port count", 2, pw_q.size());
        chk("port write 0", 32'h1c00_2180, pw_q[0]);
        chk("port write 1", 32'hffee_1234, pw_q[1]);
        chk("delay runs", 2, low_q.size());
        chk("delay one", 1, low_q[0] >= 1 && low_q[0] <= 4);
        chk("delay forty", 1, low_q[1] >= 40 && low_q[1] <= 43);
        chk("ports before memory", 1, last_port < first_mem);
        chk("mem count", 6, mw_q.size());
        for (int i = 0; i < 6; i++) chk("mem write", {adr[i], dat[i]}, mw_q[i]);
        chk("entry low save", {24'h60, 16'h3456}, ww_q[0]);
        chk("entry high save", {24'h61, 16'h0012}, ww_q[1]);
        chk("entry", 24'h12_3456, entry_o);
        chk("rdy after end", 0, byte_rdy_o);
        chk("trailing byte left", 1, media_u.q_byte.size());
    endtask : scen_full

    // same table at two source paces, preceded by a reset in mid-table
    task automatic scen_min(input int g);
        do_reset(4);
        put_field(32'h0012_3456, 0);
        put_field(32'h0000_0005, 0);
        repeat (12) @(negedge mclk_i);
        do_reset(3);
        put_field(32'h0000_0400, g);
        put_field(32'h0000_0000, g);
        put_field(32'h0000_0001, g);
        put_field(32'h0000_0300, g);
        media_u.push(8'h5a, g + 2);
        put_field(32'h0000_0000, g);
        wait_done();
        chk("no port writes", 0, pw_q.size());
        chk("one mem write", 1, mw_q.size());
        chk("mem byte", {24'h300, 8'h5a}, mw_q[0]);
        chk("entry low save", {24'h60, 16'h0400}, ww_q[0]);
        chk("entry high save", {24'h61, 16'h0000}, ww_q[1]);
        chk("entry", 24'h00_0400, entry_o);
    endtask : scen_min

    // a write as the last entry must hand over straight to the sections
    task automatic scen_last_write();
        do_reset(2);
        put_field(32'h0000_0800, 0);
        put_field(32'h0000_0001, 0);
        put_field(32'h0100_abcd, 0);
        put_field(32'h0000_0000, 0);
        wait_done();
        chk("last port count", 1, pw_q.size());
        chk("last port write", 32'h0100_abcd, pw_q[0]);
        chk("no section writes", 0, mw_q.size());
        chk("entry", 24'h00_0800, entry_o);
    endtask : scen_last_write

    // ========================================================================
    // main sequence and watchdog
    // ========================================================================
    initial begin
        nrst_i    = 1'b0;
        err_total = 0;
        n_tests   = 0;
        cyc       = 0;
        low_run   = 0;
        first_mem = -1;
        last_port = 0;
        scen_full();
        scen_min(0);
        scen_min(3);
        scen_last_write();
        finish_test();
    end

    // whole run needs well under a thousand cycles; this leaves ample margin
    initial begin
        repeat (20000) @(posedge mclk_i);
        err_total++;
        finish_test();
    end
endmodule : boot_table_interpreter_tb
`default_nettype wire

// file: verif/bti_boot_media.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================================
// boot medium model: streams a prebuilt table byte by byte
// ============================================================================
module bti_boot_media (
    // clock
    input  wire logic       mclk_i,
    // byte stream
    input  wire logic       byte_rdy_i,
    output logic            byte_vld_o,
    output logic [7:0]      byte_o
);
    logic [7:0] q_byte[$];
    int         q_gap[$];
    int         wait_cnt;
    logic       taken;
    logic [7:0] last;

    // gap is the count of idle cycles after this byte is taken
    task automatic push(input logic [7:0] b, input int gap);
        q_byte.push_back(b);
        q_gap.push_back(gap);
    endtask : push

    task automatic flush();
        q_byte.delete();
        q_gap.delete();
        wait_cnt = 0;
    endtask : flush

    initial begin
        byte_vld_o = 1'b0;
        byte_o     = 8'h00;
        last       = 8'h00;
        wait_cnt   = 0;
        taken      = 1'b0;
    end

    always @(posedge mclk_i) begin
        taken <= byte_vld_o & byte_rdy_i;
    end

    // byte held until taken; idle line shows the inverse so stale data never matches
    always @(negedge mclk_i) begin
        if (taken && q_byte.size() > 0) begin
            last     = q_byte.pop_front();
            wait_cnt = q_gap.pop_front();
        end else if (wait_cnt > 0) begin
            wait_cnt = wait_cnt - 1;
        end
        if (wait_cnt == 0 && q_byte.size() > 0) begin
            byte_vld_o = 1'b1;
            byte_o     = q_byte[0];
        end else begin
            byte_vld_o = 1'b0;
            byte_o     = ~last;
        end
    end
endmodule : bti_boot_media
`default_nettype wire
